// File: hdl/hbt_bridge.sv
// Host bridge init, role, window decode and three timeout timers.
// Assumes synchronous inputs, one clock, AXI4-Lite configuration port.
`timescale 1ns/1ps
module hbt_bridge (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  input  wire logic [7:0]  s_awaddr_i,
  input  wire logic        s_awvalid_i,
  output logic             s_awready_o,
  input  wire logic [31:0] s_wdata_i,
  input  wire logic [3:0]  s_wstrb_i,
  input  wire logic        s_wvalid_i,
  output logic             s_wready_o,
  output logic [1:0]       s_bresp_o,
  output logic             s_bvalid_o,
  input  wire logic        s_bready_i,
  input  wire logic [7:0]  s_araddr_i,
  input  wire logic        s_arvalid_i,
  output logic             s_arready_o,
  output logic [31:0]      s_rdata_o,
  output logic [1:0]       s_rresp_o,
  output logic             s_rvalid_o,
  input  wire logic        s_rready_i,
  input  wire logic        host_cyc_i,
  input  wire logic [19:0] host_addr_i,
  input  wire logic        remote_done_i,
  output logic             window_hit_o,
  output logic             host_end_o,
  output logic             remote_suspend_o,
  input  wire logic        remote_cyc_i,
  input  wire logic [23:0] remote_addr_i,
  input  wire logic        remote_comm_i,
  input  wire logic        host_bus_grant_i,
  input  wire logic        xfer_busy_i,
  output logic             remote_ack_o,
  output logic             remote_berr_o,
  output logic             dma_req_o,
  output logic             host_release_o,
  input  wire logic        sys_cyc_i,
  input  wire logic        sys_done_i,
  output logic             sys_ctrl_o,
  output logic             sys_berr_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  board_ctrl_ff;
  logic [15:0] slave_base_ff;
  logic [15:0] slave_map_ff;
  logic [7:0]  window_ff;
  logic [15:0] cnt_ff [3];
  logic [2:0]  armed_ff;
  logic [1:0]  sel_ff;
  hbt_pkg::hbt_load_t load_ff;
  logic [3:0]  fdiv_ff;
  logic [6:0]  sdiv_ff;
  logic        ftick_ff;
  logic        stick_ff;
  logic [15:0] rtmr_ff;
  logic [15:0] stmr_ff;
  logic [15:0] ctmr_ff;
  logic        rrun_ff;
  logic        srun_ff;
  logic        crun_ff;
  logic        aw_ok_ff;
  logic        w_ok_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic [2:0]  expired_ff;
  logic        slave_en;
  logic        win_en;
  logic        do_write;

  function automatic logic [1:0] tsel(input logic [7:0] ofs);
    unique case (ofs)
      hbt_pkg::SLAVE_TMR_OFS: tsel = hbt_pkg::SEL_SLAVE;
      hbt_pkg::READY_TMR_OFS: tsel = hbt_pkg::SEL_READY;
      default:                tsel = hbt_pkg::SEL_CTRL;
    endcase
  endfunction

  function automatic logic [15:0] dec(input logic [15:0] v);
    dec = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
  endfunction

  assign slave_en = slave_map_ff[hbt_pkg::SLAVE_EN_BIT];
  assign win_en   = window_ff[hbt_pkg::WINDOW_EN_BIT];
  assign do_write = aw_ok_ff && w_ok_ff && !s_bvalid_o;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data latched in either order
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_ok_ff    <= 1'b0;
      w_ok_ff     <= 1'b0;
      awaddr_ff   <= 8'h00;
      wdata_ff    <= 32'h0000_0000;
      wstrb_ff    <= 4'h0;
      s_awready_o <= 1'b0;
      s_wready_o  <= 1'b0;
      s_bvalid_o  <= 1'b0;
      s_bresp_o   <= hbt_pkg::RESP_OKAY;
    end else if (ce_i) begin
      s_awready_o <= !aw_ok_ff && !s_awready_o && !s_bvalid_o;
      s_wready_o  <= !w_ok_ff && !s_wready_o && !s_bvalid_o;
      if (s_awvalid_i && s_awready_o) begin
        aw_ok_ff  <= 1'b1;
        awaddr_ff <= s_awaddr_i;
        s_awready_o <= 1'b0;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_ok_ff  <= 1'b1;
        wdata_ff <= s_wdata_i;
        wstrb_ff <= s_wstrb_i;
        s_wready_o <= 1'b0;
      end
      if (do_write) begin
        aw_ok_ff   <= 1'b0;
        w_ok_ff    <= 1'b0;
        s_bvalid_o <= 1'b1;
        s_bresp_o  <= (awaddr_ff > hbt_pkg::STATUS_OFS ||
                       awaddr_ff[1:0] != 2'h0) ?
                      hbt_pkg::RESP_DECERR : hbt_pkg::RESP_OKAY;
      end else if (s_bvalid_o && s_bready_i) begin
        s_bvalid_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration holds until rewritten or reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      board_ctrl_ff <= 8'h00;
      slave_base_ff <= 16'h0000;
      slave_map_ff  <= 16'h0000;
      window_ff     <= 8'h00;
    end else if (ce_i && do_write && wstrb_ff[0]) begin
      unique case (awaddr_ff)
        hbt_pkg::BOARD_CTRL_OFS: board_ctrl_ff <= wdata_ff[7:0];
        hbt_pkg::SLAVE_BASE_OFS: slave_base_ff <= wdata_ff[15:0];
        hbt_pkg::SLAVE_MAP_OFS:  slave_map_ff  <= wdata_ff[15:0];
        hbt_pkg::WINDOW_OFS:     window_ff     <= wdata_ff[7:0];
        default: ;
      endcase
    end
  end

  // Timer load sequence: control byte, then low byte, then high byte
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      load_ff  <= hbt_pkg::LD_IDLE;
      sel_ff   <= hbt_pkg::SEL_SLAVE;
      armed_ff <= 3'h0;
      for (int i = 0; i < 3; i++) cnt_ff[i] <= 16'h0000;
    end else if (ce_i && do_write && wstrb_ff[0]) begin
      if (awaddr_ff == hbt_pkg::TIMER_CTRL_OFS) begin
        // Wrong mode pattern or reserved select leaves loader idle
        if (wdata_ff[5:0] == hbt_pkg::TIMER_MODE &&
            wdata_ff[7:6] != 2'h3) begin
          sel_ff  <= wdata_ff[7:6];
          load_ff <= hbt_pkg::LD_LOW;
          armed_ff[wdata_ff[7:6]] <= 1'b0;
        end else begin
          load_ff <= hbt_pkg::LD_IDLE;
        end
      end else if (awaddr_ff >= hbt_pkg::SLAVE_TMR_OFS &&
                   awaddr_ff <= hbt_pkg::CTRL_TMR_OFS &&
                   tsel(awaddr_ff) == sel_ff) begin
        unique case (load_ff)
          hbt_pkg::LD_LOW: begin
            cnt_ff[sel_ff][7:0] <= wdata_ff[7:0];
            load_ff <= hbt_pkg::LD_HIGH;
          end
          hbt_pkg::LD_HIGH: begin
            cnt_ff[sel_ff][15:8] <= wdata_ff[7:0];
            armed_ff[sel_ff] <= 1'b1;
            load_ff <= hbt_pkg::LD_IDLE;
          end
          hbt_pkg::LD_IDLE: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_arready_o <= 1'b0;
      s_rvalid_o  <= 1'b0;
      s_rdata_o   <= hbt_pkg::RESET_ZERO;
      s_rresp_o   <= hbt_pkg::RESP_OKAY;
    end else if (ce_i) begin
      s_arready_o <= !s_arready_o && !s_rvalid_o;
      if (s_arvalid_i && s_arready_o) begin
        s_arready_o <= 1'b0;
        s_rvalid_o  <= 1'b1;
        s_rresp_o   <= hbt_pkg::RESP_OKAY;
        s_rdata_o   <= 32'h0000_0000;
        unique case (s_araddr_i)
          hbt_pkg::BOARD_CTRL_OFS: s_rdata_o[7:0]  <= board_ctrl_ff;
          hbt_pkg::SLAVE_BASE_OFS: s_rdata_o[15:0] <= slave_base_ff;
          hbt_pkg::SLAVE_MAP_OFS:  s_rdata_o[15:0] <= slave_map_ff;
          hbt_pkg::WINDOW_OFS:     s_rdata_o[7:0]  <= window_ff;
          hbt_pkg::SLAVE_TMR_OFS:  s_rdata_o[15:0] <= cnt_ff[0];
          hbt_pkg::READY_TMR_OFS:  s_rdata_o[15:0] <= cnt_ff[1];
          hbt_pkg::CTRL_TMR_OFS:   s_rdata_o[15:0] <= cnt_ff[2];
          hbt_pkg::TIMER_CTRL_OFS: s_rdata_o[7:0]  <= {sel_ff, 6'h00};
          hbt_pkg::STATUS_OFS:     s_rdata_o[5:0]  <=
                                   {expired_ff, armed_ff};
          default:                 s_rresp_o <= hbt_pkg::RESP_DECERR;
        endcase
      end else if (s_rvalid_o && s_rready_i) begin
        s_rvalid_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick prescalers from the system clock
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fdiv_ff  <= 4'h0;
      sdiv_ff  <= 7'h00;
      ftick_ff <= 1'b0;
      stick_ff <= 1'b0;
    end else if (ce_i) begin
      ftick_ff <= (fdiv_ff == 4'(hbt_pkg::FAST_DIV - 1));
      fdiv_ff  <= (fdiv_ff == 4'(hbt_pkg::FAST_DIV - 1)) ?
                  4'h0 : fdiv_ff + 4'h1;
      stick_ff <= (sdiv_ff == 7'(hbt_pkg::SLOW_DIV - 1));
      sdiv_ff  <= (sdiv_ff == 7'(hbt_pkg::SLOW_DIV - 1)) ?
                  7'h00 : sdiv_ff + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master-mode window and ready timer. Prescaler phase is free running,
  // so the limit carries up to one tick of slack short.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rtmr_ff          <= 16'h0000;
      rrun_ff          <= 1'b0;
      window_hit_o     <= 1'b0;
      host_end_o       <= 1'b0;
      remote_suspend_o <= 1'b0;
    end else if (ce_i) begin
      window_hit_o <= win_en && host_cyc_i && !host_end_o &&
                      host_addr_i[19:16] == window_ff[7:4];
      host_end_o   <= 1'b0;
      if (!host_cyc_i) begin
        rrun_ff          <= 1'b0;
        remote_suspend_o <= remote_suspend_o && !remote_done_i;
      end else if (window_hit_o && !rrun_ff && !host_end_o &&
                   armed_ff[1]) begin
        rrun_ff <= 1'b1;
        rtmr_ff <= cnt_ff[1];
      end else if (rrun_ff && remote_done_i) begin
        rrun_ff    <= 1'b0;
        host_end_o <= 1'b1;
      end else if (rrun_ff && ftick_ff) begin
        rtmr_ff <= dec(rtmr_ff);
        if (rtmr_ff <= 16'h0001) begin
          rrun_ff          <= 1'b0;
          host_end_o       <= 1'b1;
          remote_suspend_o <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave mode: decode, DMA request, hold timer
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stmr_ff        <= 16'h0000;
      srun_ff        <= 1'b0;
      remote_ack_o   <= 1'b0;
      remote_berr_o  <= 1'b0;
      dma_req_o      <= 1'b0;
      host_release_o <= 1'b0;
    end else if (ce_i) begin
      remote_ack_o  <= 1'b0;
      remote_berr_o <= 1'b0;
      if (remote_cyc_i && remote_comm_i) begin
        remote_ack_o <= 1'b1;
      end else if (remote_cyc_i &&
                   (!slave_en || !armed_ff[0])) begin
        remote_berr_o <= 1'b1;
      end else if (remote_cyc_i &&
                   ((remote_addr_i[23:16] ^ slave_base_ff[15:8]) &
                    slave_map_ff[15:8]) == 8'h00) begin
        dma_req_o <= !host_release_o;
        remote_ack_o <= host_bus_grant_i && !xfer_busy_i;
      end else if (remote_cyc_i) begin
        remote_berr_o <= 1'b1;
      end
      // Reload while idle; a zero count after expiry blocks a restart
      if (!host_bus_grant_i) begin
        srun_ff        <= 1'b0;
        host_release_o <= 1'b0;
        stmr_ff        <= cnt_ff[0];
        if (!remote_cyc_i) dma_req_o <= 1'b0;
      end else if (!srun_ff && !host_release_o && stmr_ff != 16'h0000) begin
        srun_ff <= 1'b1;
      end else if (srun_ff && ftick_ff) begin
        stmr_ff <= dec(stmr_ff);
        if (stmr_ff <= 16'h0001) srun_ff <= 1'b0;
      end else if (!srun_ff && !xfer_busy_i) begin
        host_release_o <= 1'b1;
        dma_req_o      <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System-controller role and transfer timer
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctmr_ff    <= 16'h0000;
      crun_ff    <= 1'b0;
      sys_ctrl_o <= 1'b0;
      sys_berr_o <= 1'b0;
      expired_ff <= 3'h0;
    end else if (ce_i) begin
      sys_ctrl_o <= board_ctrl_ff[hbt_pkg::SYS_CTRL_BIT];
      sys_berr_o <= 1'b0;
      expired_ff <= expired_ff | {1'b0, remote_suspend_o, host_release_o};
      if (!sys_cyc_i || sys_done_i || !sys_ctrl_o || !armed_ff[2]) begin
        crun_ff <= sys_cyc_i && !sys_done_i && crun_ff && sys_ctrl_o;
        if (sys_cyc_i && !crun_ff && !sys_done_i && sys_ctrl_o &&
            armed_ff[2]) begin
          crun_ff <= 1'b1;
          ctmr_ff <= cnt_ff[2];
        end
      end else if (!crun_ff) begin
        crun_ff <= 1'b1;
        ctmr_ff <= cnt_ff[2];
      end else if (stick_ff) begin
        ctmr_ff <= dec(ctmr_ff);
        if (ctmr_ff <= 16'h0001) begin
          sys_berr_o    <= 1'b1;
          crun_ff       <= 1'b0;
          expired_ff[2] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_passive;
    @(posedge clk_i) disable iff (srst_i)
      !win_en |=> !window_hit_o;
  endproperty
  a_passive: assert property (p_passive) else $error("window w/o enable");

  property p_berr_unslaved;
    @(posedge clk_i) disable iff (srst_i)
      ce_i && remote_cyc_i && !remote_comm_i && !slave_en |=>
        remote_berr_o && !remote_ack_o;
  endproperty
  a_berr_unslaved: assert property (p_berr_unslaved) else $error("no berr");

  property p_comm_any;
    @(posedge clk_i) disable iff (srst_i)
      ce_i && remote_cyc_i && remote_comm_i |=> remote_ack_o;
  endproperty
  a_comm_any: assert property (p_comm_any) else $error("comm refused");

  property p_sysctrl;
    @(posedge clk_i) disable iff (srst_i)
      ce_i |=> sys_ctrl_o == $past(board_ctrl_ff[7]);
  endproperty
  a_sysctrl: assert property (p_sysctrl) else $error("role mismatch");

  property p_ready_end;
    @(posedge clk_i) disable iff (srst_i)
      $rose(remote_suspend_o) |-> host_end_o;
  endproperty
  a_ready_end: assert property (p_ready_end) else $error("no host end");

  property p_release_idle;
    @(posedge clk_i) disable iff (srst_i)
      $rose(host_release_o) |-> $past(!xfer_busy_i);
  endproperty
  a_release_idle: assert property (p_release_idle) else $error("early release");

  property p_berr_role;
    @(posedge clk_i) disable iff (srst_i)
      sys_berr_o |-> $past(sys_ctrl_o) && armed_ff[2];
  endproperty
  a_berr_role: assert property (p_berr_role) else $error("stray berr");

  property p_tick;
    @(posedge clk_i) disable iff (srst_i)
      ce_i && ftick_ff ##1 ce_i |-> !ftick_ff;
  endproperty
  a_tick: assert property (p_tick) else $error("tick too wide");

  c_berr: cover property (@(posedge clk_i) sys_berr_o);
  c_suspend: cover property (@(posedge clk_i) $rose(remote_suspend_o));
  c_release: cover property (@(posedge clk_i) $rose(host_release_o));
  c_hit: cover property (@(posedge clk_i) window_hit_o);
endmodule

// File: hdl/hbt_pkg.sv
// Constants for the host bridge init and timeout block.
// Assumes one 125 MHz clock and an AXI4-Lite master for configuration.
package hbt_pkg;
  localparam logic [7:0] BOARD_CTRL_OFS    = 8'h00;
  localparam logic [7:0] SLAVE_BASE_OFS    = 8'h04;
  localparam logic [7:0] SLAVE_MAP_OFS     = 8'h08;
  localparam logic [7:0] WINDOW_OFS        = 8'h0C;
  localparam logic [7:0] SLAVE_TMR_OFS     = 8'h10;
  localparam logic [7:0] READY_TMR_OFS     = 8'h14;
  localparam logic [7:0] CTRL_TMR_OFS      = 8'h18;
  localparam logic [7:0] TIMER_CTRL_OFS    = 8'h1C;
  localparam logic [7:0] STATUS_OFS        = 8'h20;
  localparam int         SYS_CTRL_BIT      = 7;
  localparam int         WINDOW_EN_BIT     = 0;
  localparam int         SLAVE_EN_BIT      = 0;
  localparam logic [5:0] TIMER_MODE        = 6'h34;
  localparam logic [1:0] SEL_SLAVE         = 2'h0;
  localparam logic [1:0] SEL_READY         = 2'h1;
  localparam logic [1:0] SEL_CTRL          = 2'h2;
  localparam int         CLK_HZ            = 125000000;
  localparam int         FAST_TICK_HZ      = 10000000;
  localparam int         SLOW_TICK_HZ      = 1250000;
  localparam int         FAST_DIV          = CLK_HZ / FAST_TICK_HZ;
  localparam int         SLOW_DIV          = CLK_HZ / SLOW_TICK_HZ;
  localparam int         HOLD_MAX_NS       = 15000;
  localparam int         LOGIC_DELAY_NS    = 200;
  localparam logic [15:0] READY_CNT_REC    = 16'h0094;
  localparam logic [15:0] SLAVE_CNT_REC    = 16'h007B;
  localparam logic [15:0] CTRL_CNT_REC     = 16'h04E2;
  localparam int         WIN_ADDR_W        = 20;
  localparam logic [31:0] RESET_ZERO       = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY         = 2'h0;
  localparam logic [1:0] RESP_SLVERR       = 2'h2;
  localparam logic [1:0] RESP_DECERR       = 2'h3;
  typedef enum logic [1:0] {LD_IDLE, LD_LOW, LD_HIGH} hbt_load_t;
endpackage

// File: sim/hbt_bridge_tb_top.sv
// Bench for the bridge: AXI4-Lite tasks, far-side model, timer scenarios.
// Assumes timer counts shrunk to a few ticks to keep runs short.
`timescale 1ns/1ps
module hbt_bridge_tb_top;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [7:0]  s_awaddr_i = 8'h00, s_araddr_i = 8'h00;
  logic [31:0] s_wdata_i = 32'h0, s_rdata_o, rd;
  logic        s_awvalid_i = 1'b0, s_wvalid_i = 1'b0, s_bready_i = 1'b0;
  logic        s_arvalid_i = 1'b0, s_rready_i = 1'b0;
  logic        s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
  logic [1:0]  s_bresp_o, s_rresp_o, rsp;
  logic [19:0] host_adr = 20'h00000, host_addr_i;
  logic [23:0] remote_addr_i = 24'h000000;
  logic        host_go = 1'b0, slow = 1'b0, xfer_busy_i = 1'b0;
  logic        remote_cyc_i = 1'b0, remote_comm_i = 1'b0;
  logic        sys_cyc_i = 1'b0, sys_done_i = 1'b0;
  logic        host_cyc_i, remote_done_i, host_bus_grant_i, sys_berr_o;
  logic        window_hit_o, host_end_o, remote_suspend_o, remote_ack_o;
  logic        remote_berr_o, dma_req_o, host_release_o, sys_ctrl_o;
  logic [15:0] cnt [3] = '{16'h0003, 16'h0004, 16'h0002};
  int          miscompares = 0, tests_run = 0, cycles = 0, n, sb_cnt = 0;
  hbt_bridge i_dut (
    .clk_i, .srst_i, .ce_i(1'b1), .s_awaddr_i, .s_awvalid_i, .s_awready_o,
    .s_wdata_i, .s_wstrb_i(4'hF), .s_wvalid_i, .s_wready_o, .s_bresp_o,
    .s_bvalid_o, .s_bready_i, .s_araddr_i, .s_arvalid_i, .s_arready_o,
    .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i, .host_cyc_i,
    .host_addr_i, .remote_done_i, .window_hit_o, .host_end_o,
    .remote_suspend_o, .remote_cyc_i, .remote_addr_i, .remote_comm_i,
    .host_bus_grant_i, .xfer_busy_i, .remote_ack_o, .remote_berr_o,
    .dma_req_o, .host_release_o, .sys_cyc_i, .sys_done_i, .sys_ctrl_o,
    .sys_berr_o);
  hbt_far_model i_far (
    .clk_i, .srst_i, .host_go_i(host_go), .host_adr_i(host_adr),
    .slow_i(slow), .window_hit_i(window_hit_o), .host_end_i(host_end_o),
    .remote_suspend_i(remote_suspend_o), .dma_req_i(dma_req_o),
    .host_cyc_o(host_cyc_i), .host_addr_o(host_addr_i),
    .remote_done_o(remote_done_i), .host_bus_grant_o(host_bus_grant_i));
  //////////////////////////////////////////////////////////////////////////
  always #4 clk_i = ~clk_i;
  // Hang guard sized well above the thousand or so cycles the tests need
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (sys_berr_o === 1'b1) sb_cnt <= sb_cnt + 1;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    s_awaddr_i  <= a;
    s_wdata_i   <= d;
    s_awvalid_i <= 1'b1;
    s_wvalid_i  <= 1'b1;
    s_bready_i  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_awready_o) s_awvalid_i <= 1'b0;
      if (s_wready_o) s_wvalid_i <= 1'b0;
    end while (s_bvalid_o !== 1'b1);
    rsp = s_bresp_o;
    s_bready_i <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk_i);
    s_araddr_i  <= a;
    s_arvalid_i <= 1'b1;
    s_rready_i  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_arready_o) s_arvalid_i <= 1'b0;
    end while (s_rvalid_o !== 1'b1);
    rd = s_rdata_o;
    rsp = s_rresp_o;
    s_rready_i <= 1'b0;
  endtask
  function automatic logic sg(input int k);
    case (k)
      0: return host_end_o;
      1: return sys_berr_o;
      2: return remote_ack_o;
      3: return remote_berr_o;
      4: return dma_req_o;
      5: return window_hit_o;
      default: return host_release_o;
    endcase
  endfunction
  // Cycles until the chosen output is high, -1 if it never came
  task automatic wt(input int k, input int lim);
    n = 0;
    while (sg(k) !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (sg(k) !== 1'b1) n = -1;
  endtask
  task automatic prog(input logic [1:0] s, input logic [15:0] c);
    wr(hbt_pkg::TIMER_CTRL_OFS, {24'h0, s, hbt_pkg::TIMER_MODE});
    wr(hbt_pkg::SLAVE_TMR_OFS + {4'h0, s, 2'h0}, {24'h0, c[7:0]});
    wr(hbt_pkg::SLAVE_TMR_OFS + {4'h0, s, 2'h0}, {24'h0, c[15:8]});
  endtask
  task automatic rem(input logic [23:0] a, input logic c, input int k);
    @(posedge clk_i);
    remote_addr_i <= a;
    remote_comm_i <= c;
    remote_cyc_i  <= 1'b1;
    wt(k, 80);
    remote_cyc_i  <= 1'b0;
    remote_addr_i <= ~a;
  endtask
  task automatic host(input logic [19:0] a, input logic s, input int k);
    @(posedge clk_i);
    host_adr <= a;
    slow     <= s;
    host_go  <= 1'b1;
    wt(k, 200);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    rdr(hbt_pkg::BOARD_CTRL_OFS);
    chk(rd, 32'h0);
    rdr(hbt_pkg::STATUS_OFS);
    chk(rd, 32'h0);
    rem(24'h150000, 1'b0, 3);
    chk(32'(n >= 0 && n < 4), 32'h1);
    rem(24'h150000, 1'b1, 2);
    chk(32'(n >= 0 && n < 4), 32'h1);
    rdr(8'h40);
    chk(32'(rsp), 32'(hbt_pkg::RESP_DECERR));
    $display("test reset done");
    wr(hbt_pkg::BOARD_CTRL_OFS, 32'h80);
    @(posedge clk_i);
    chk(32'(sys_ctrl_o), 32'h1);
    wr(hbt_pkg::TIMER_CTRL_OFS, 32'h0);
    wr(hbt_pkg::SLAVE_TMR_OFS, 32'h3);
    wr(hbt_pkg::SLAVE_TMR_OFS, 32'h0);
    rdr(hbt_pkg::STATUS_OFS);
    chk(rd & 32'h7, 32'h0);
    for (int i = 0; i < 3; i++) begin
      prog(2'(i), cnt[i]);
      rdr(hbt_pkg::STATUS_OFS);
      chk(rd & 32'h7, (32'h2 << i) - 32'h1);
    end
    $display("test timers done");
    host(20'hD1234, 1'b0, 5);
    chk(32'(n), 32'hFFFFFFFF);
    host_go <= 1'b0;
    wr(hbt_pkg::WINDOW_OFS, 32'hD1);
    host(20'hE1234, 1'b0, 5);
    chk(32'(n), 32'hFFFFFFFF);
    host_go <= 1'b0;
    host(20'hD8000, 1'b0, 0);
    chk(32'(n >= 0), 32'h1);
    chk(32'(remote_suspend_o), 32'h0);
    host_go <= 1'b0;
    host(20'hD0010, 1'b1, 0);
    chk(32'(n >= 36 && n <= 60), 32'h1);
    chk(32'(n * 8 <= hbt_pkg::HOLD_MAX_NS - hbt_pkg::LOGIC_DELAY_NS), 32'h1);
    @(posedge clk_i);
    chk(32'(remote_suspend_o), 32'h1);
    wt(0, 40);
    chk(32'(n >= 0), 32'h1);
    host_go <= 1'b0;
    $display("test window done");
    sys_cyc_i <= 1'b1;
    wt(1, 400);
    chk(32'(n >= 100 && n <= 210), 32'h1);
    // Three 90-cycle cycles would overrun a timer that failed to restart
    @(posedge clk_i);
    n = sb_cnt;
    repeat (3) begin
      repeat (90) @(posedge clk_i);
      sys_done_i <= 1'b1;
      @(posedge clk_i);
      sys_done_i <= 1'b0;
    end
    sys_cyc_i <= 1'b0;
    chk(32'(sb_cnt - n), 32'h0);
    $display("test controller done");
    wr(hbt_pkg::SLAVE_BASE_OFS, 32'h1400);
    wr(hbt_pkg::SLAVE_MAP_OFS, 32'hFE01);
    rem(24'h160000, 1'b0, 3);
    chk(32'(n >= 0), 32'h1);
    xfer_busy_i <= 1'b1;
    @(posedge clk_i);
    remote_addr_i <= 24'h150000;
    remote_comm_i <= 1'b0;
    remote_cyc_i  <= 1'b1;
    wt(4, 80);
    chk(32'(n >= 0), 32'h1);
    repeat (80) @(posedge clk_i);
    chk(32'(host_release_o), 32'h0);
    xfer_busy_i <= 1'b0;
    wt(6, 10);
    chk(32'(n >= 0), 32'h1);
    remote_cyc_i <= 1'b0;
    rdr(hbt_pkg::WINDOW_OFS);
    chk(rd, 32'hD1);
    $display("test slave done");
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    rdr(hbt_pkg::SLAVE_MAP_OFS);
    chk(rd, 32'h0);
    chk(32'(sys_ctrl_o), 32'h0);
    $display("test rereset done");
    summarize();
  end
endmodule

// File: sim/hbt_far_model.sv
// Far-side model: host bus master plus the cascade DMA controller.
// Assumes the bench starts each host cycle by raising host_go_i.
`timescale 1ns/1ps
module hbt_far_model (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        host_go_i,
  input  wire logic [19:0] host_adr_i,
  input  wire logic        slow_i,
  input  wire logic        window_hit_i,
  input  wire logic        host_end_i,
  input  wire logic        remote_suspend_i,
  input  wire logic        dma_req_i,
  output logic             host_cyc_o,
  output logic [19:0]      host_addr_o,
  output logic             remote_done_o,
  output logic             host_bus_grant_o
);
  logic [19:0] adr_ff;
  logic [1:0]  wait_ff;
  logic        go_ff;
  logic        retry_ff;
  logic        again_ff;
  logic        req_ff;
  //////////////////////////////////////////////////////////////////////////
  // Released address lines show the inverse, never a stale value
  assign host_addr_o = host_cyc_o ? adr_ff : ~adr_ff;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      {host_cyc_o, go_ff, retry_ff, again_ff} <= 4'h0;
      adr_ff        <= 20'h00000;
      wait_ff       <= 2'h0;
      remote_done_o <= 1'b0;
    end else begin
      go_ff    <= host_go_i;
      retry_ff <= host_end_i & remote_suspend_i;
      wait_ff  <= (host_cyc_o & window_hit_i) ? wait_ff + 2'h1 : 2'h0;
      // Slow remote slave finishes only on the retried access
      remote_done_o <= host_cyc_o & window_hit_i & (wait_ff == 2'h2) &
                       (~slow_i | again_ff);
      if (host_go_i & ~go_ff) begin
        host_cyc_o <= 1'b1;
        adr_ff     <= host_adr_i;
        again_ff   <= 1'b0;
      end else if (retry_ff & host_go_i) begin
        host_cyc_o <= 1'b1;
        again_ff   <= 1'b1;
      end else if (host_end_i | ~host_go_i) begin
        host_cyc_o <= 1'b0;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Cascade channel only grants the bus, two cycles after the request rises if it stays high
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      req_ff           <= 1'b0;
      host_bus_grant_o <= 1'b0;
    end else begin
      req_ff           <= dma_req_i;
      host_bus_grant_o <= req_ff & dma_req_i;
    end
  end
endmodule
